// file: shared/rdioh_pkg.sv
// Constants and types for the dedicated I/O handler
`default_nettype none
package rdioh_pkg;
  localparam int AXES        = 8;
  localparam int MECHS       = 3;
  localparam int HAND_W      = 8;
  localparam int NUM_W       = 16;
  localparam int ZONE_W      = 8;
  localparam int ZONE_IDX_W  = 3;
  localparam int JOG_MODE_W  = 2;
  localparam logic [NUM_W-1:0]      NUM_RST      = 16'h0000;
  localparam logic [JOG_MODE_W-1:0] JOG_MODE_RST = 2'h0;
  // Numeric port layout, fixed order: input start, input end, output start, output end
  localparam int NUM_IN_START  = 0;
  localparam int NUM_IN_END    = NUM_W - 1;
  localparam int NUM_OUT_START = 0;
  localparam int NUM_OUT_END   = NUM_W - 1;
  typedef enum logic [1:0] {
    RDIOH_SRC_NONE,
    RDIOH_SRC_OVR,
    RDIOH_SRC_ERR
  } rdioh_src_e;
endpackage
`default_nettype wire

// file: shared/rdioh_edge_if.sv
// Carrier between the input sampler and the main handler
`timescale 1ns/1ps
`default_nettype none
interface rdioh_edge_if;
  logic ovrReq;
  logic errReq;
  logic jogEnaReq;
  logic ovrRise;
  logic errRise;
  logic jogEnaRise;
  modport sampler (input ovrReq, errReq, jogEnaReq, output ovrRise, errRise, jogEnaRise);
  modport user    (output ovrReq, errReq, jogEnaReq, input ovrRise, errRise, jogEnaRise);
endinterface
`default_nettype wire

// file: hw/rdioh_edge_detect.sv
// Rising-edge detector for edge-type inputs
`timescale 1ns/1ps
`default_nettype none
module rdioh_edge_detect (
  input  wire logic    ref_clk,
  input  wire logic    sys_rst,
  rdioh_edge_if.sampler edg
);
  logic [2:0] prev_r;
  logic [2:0] cur;

  assign cur = {edg.jogEnaReq, edg.errReq, edg.ovrReq};

  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      prev_r <= '1;
    end else begin
      prev_r <= cur;
    end
  end

  assign edg.ovrRise    = cur[0] & ~prev_r[0];
  assign edg.errRise    = cur[1] & ~prev_r[1];
  assign edg.jogEnaRise = cur[2] & ~prev_r[2];
endmodule
`default_nettype wire

// file: hw/rdioh_top.sv
// Dedicated external-signal handler of the robot controller
// Overview of operation
// - A level input keeps its function only while it is ON and drops it when OFF.
// - An edge input acts on OFF-to-ON and its result holds after the input goes OFF.
// - An override request edge puts the override value on the numeric outputs and flags it.
// - An error-number request edge puts the error number on the numeric outputs and flags it.
// - A jog-enable edge validates external jog and a jog-valid output shows it.
// - The 2-bit jog mode is taken as a level and the active mode is reported.
// - Plus and minus jog feed for 8 axes are level requests honoured only while ON.
// - Hand output status mirrors general outputs 900-907, 910-917, 920-927 per mechanism.
// - Hand input status mirrors hand inputs 900-907, 910-917, 920-927 per mechanism.
// - Each mechanism's hand fault input raises its hand fault output while ON.
// - Each mechanism's pneumatic fault input raises its pneumatic output while ON.
// - Each mechanism's parts warning is asserted once replacement time is reached.
// - User zone outputs, up to eight, sit between a start and an end output number.
// - The numeric port is set by input start, input end, output start, output end.
// - The numeric output tracks the current value of the last requested quantity; inputs carry outside values.
`timescale 1ns/1ps
`default_nettype none
module rdioh_top
  import rdioh_pkg::*;
(
  input  wire logic                                 ref_clk,
  input  wire logic                                 sys_rst,
  input  wire logic                                 override_value_request,
  input  wire logic                                 error_number_request,
  input  wire logic                                 external_jog_enable,
  input  wire logic                                 externalJogDisable,
  input  wire logic [rdioh_pkg::JOG_MODE_W-1:0]     jog_mode_select,
  input  wire logic [rdioh_pkg::AXES-1:0]           jogPlusReq,
  input  wire logic [rdioh_pkg::AXES-1:0]           jogMinusReq,
  input  wire logic [rdioh_pkg::MECHS-1:0]          handFaultIn,
  input  wire logic [rdioh_pkg::MECHS-1:0]          pneumaticFaultIn,
  input  wire logic [rdioh_pkg::MECHS-1:0]          partsDue,
  input  wire logic [rdioh_pkg::MECHS*rdioh_pkg::HAND_W-1:0] genOutBits,
  input  wire logic [rdioh_pkg::MECHS*rdioh_pkg::HAND_W-1:0] handInBits,
  input  wire logic [rdioh_pkg::ZONE_W-1:0]         inZone,
  input  wire logic [rdioh_pkg::ZONE_IDX_W-1:0]     zoneStartIdx,
  input  wire logic [rdioh_pkg::ZONE_IDX_W-1:0]     zoneEndIdx,
  input  wire logic [rdioh_pkg::NUM_W-1:0]          overrideValue,
  input  wire logic [rdioh_pkg::NUM_W-1:0]          errorNumber,
  input  wire logic [rdioh_pkg::NUM_W-1:0]          numericIn,
  output logic [rdioh_pkg::NUM_W-1:0]               numericOut,
  output logic [rdioh_pkg::NUM_W-1:0]               numericInLatched,
  output logic                                      overrideOutFlag,
  output logic                                      errorOutFlag,
  output logic                                      jogValid,
  output logic [rdioh_pkg::JOG_MODE_W-1:0]          jogModeActive,
  output logic [rdioh_pkg::AXES-1:0]                jogPlusActive,
  output logic [rdioh_pkg::AXES-1:0]                jogMinusActive,
  output logic [rdioh_pkg::MECHS*rdioh_pkg::HAND_W-1:0] hand_output_mirror,
  output logic [rdioh_pkg::MECHS*rdioh_pkg::HAND_W-1:0] hand_input_mirror,
  output logic [rdioh_pkg::MECHS-1:0]               hand_fault,
  output logic [rdioh_pkg::MECHS-1:0]               pneumatic_fault,
  output logic [rdioh_pkg::MECHS-1:0]               parts_replacement_warning,
  output logic [rdioh_pkg::ZONE_W-1:0]              user_zone_flag
);
  import rdioh_pkg::*;

  // ==========================================================
  // Input synchronisers
  // ==========================================================
  localparam int SW = 3 + 1 + JOG_MODE_W + 2*AXES + 3*MECHS + 2*MECHS*HAND_W + ZONE_W + NUM_W;
  logic [SW-1:0] meta_r;
  logic [SW-1:0] sync_r;
  logic [SW-1:0] rawIn;

  assign rawIn = {override_value_request, error_number_request, external_jog_enable,
                  externalJogDisable, jog_mode_select, jogPlusReq, jogMinusReq,
                  handFaultIn, pneumaticFaultIn, partsDue, genOutBits, handInBits,
                  inZone, numericIn};

  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      meta_r <= '0;
      sync_r <= '0;
    end else begin
      meta_r <= rawIn;
      sync_r <= meta_r;
    end
  end

  logic                  sOvrReq;
  logic                  sErrReq;
  logic                  sJogEna;
  logic                  sJogDis;
  logic [JOG_MODE_W-1:0] sJogMode;
  logic [AXES-1:0]       sJogPlus;
  logic [AXES-1:0]       sJogMinus;
  logic [MECHS-1:0]      sHandFault;
  logic [MECHS-1:0]      sAirFault;
  logic [MECHS-1:0]      sPartsDue;
  logic [MECHS*HAND_W-1:0] sGenOut;
  logic [MECHS*HAND_W-1:0] sHandIn;
  logic [ZONE_W-1:0]     sInZone;
  logic [NUM_W-1:0]      sNumIn;

  assign {sOvrReq, sErrReq, sJogEna, sJogDis, sJogMode, sJogPlus, sJogMinus,
          sHandFault, sAirFault, sPartsDue, sGenOut, sHandIn, sInZone, sNumIn} = sync_r;

  // ==========================================================
  // Edge detection
  // ==========================================================
  rdioh_edge_if edg ();
  assign edg.ovrReq    = sOvrReq;
  assign edg.errReq    = sErrReq;
  assign edg.jogEnaReq = sJogEna;

  rdioh_edge_detect u_edge (
    .ref_clk (ref_clk),
    .sys_rst (sys_rst),
    .edg     (edg)
  );

  // ==========================================================
  // Numeric value output
  // ==========================================================
  rdioh_src_e src_r;

  // last request wins; error takes priority on a tie
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      src_r <= RDIOH_SRC_NONE;
    end else if (edg.errRise) begin
      src_r <= RDIOH_SRC_ERR;
    end else if (edg.ovrRise) begin
      src_r <= RDIOH_SRC_OVR;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      numericOut      <= NUM_RST;
      overrideOutFlag <= 1'b0;
      errorOutFlag    <= 1'b0;
    end else begin
      case (src_r)
        RDIOH_SRC_OVR: begin
          numericOut[NUM_OUT_END:NUM_OUT_START] <= overrideValue;
          overrideOutFlag <= 1'b1;
          errorOutFlag    <= 1'b0;
        end
        RDIOH_SRC_ERR: begin
          numericOut[NUM_OUT_END:NUM_OUT_START] <= errorNumber;
          overrideOutFlag <= 1'b0;
          errorOutFlag    <= 1'b1;
        end
        default: begin
          numericOut      <= NUM_RST;
          overrideOutFlag <= 1'b0;
          errorOutFlag    <= 1'b0;
        end
      endcase
    end
  end

  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      numericInLatched <= NUM_RST;
    end else begin
      numericInLatched <= sNumIn[NUM_IN_END:NUM_IN_START];
    end
  end

  // ==========================================================
  // External jog
  // ==========================================================
  // edge sets validity, held
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      jogValid <= 1'b0;
    end else if (edg.jogEnaRise) begin
      jogValid <= 1'b1;
    end else if (sJogDis) begin
      jogValid <= 1'b0;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      jogModeActive  <= JOG_MODE_RST;
      jogPlusActive  <= '0;
      jogMinusActive <= '0;
    end else begin
      jogModeActive  <= sJogMode;
      jogPlusActive  <= jogValid ? sJogPlus : '0;
      jogMinusActive <= jogValid ? sJogMinus : '0;
    end
  end

  // ==========================================================
  // Hand status, faults, warnings
  // ==========================================================
  // general output, hand input, fault and warning mirrors
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      hand_output_mirror        <= '0;
      hand_input_mirror         <= '0;
      hand_fault                <= '0;
      pneumatic_fault           <= '0;
      parts_replacement_warning <= '0;
    end else begin
      hand_output_mirror        <= sGenOut;
      hand_input_mirror         <= sHandIn;
      hand_fault                <= sHandFault;
      pneumatic_fault           <= sAirFault;
      parts_replacement_warning <= sPartsDue;
    end
  end

  // ==========================================================
  // User zones
  // ==========================================================
  function automatic logic inRange(input logic [ZONE_IDX_W-1:0] i,
                                   input logic [ZONE_IDX_W-1:0] lo,
                                   input logic [ZONE_IDX_W-1:0] hi);
    inRange = (i >= lo) && (i <= hi);
  endfunction

  logic [ZONE_W-1:0] zoneMask;
  genvar gz;
  generate
    for (gz = 0; gz < ZONE_W; gz++) begin : g_zone
      assign zoneMask[gz] = inRange(ZONE_IDX_W'(gz), zoneStartIdx, zoneEndIdx);
    end
  endgenerate

  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      user_zone_flag <= '0;
    end else begin
      user_zone_flag <= sInZone & zoneMask;
    end
  end
endmodule
`default_nettype wire

// file: bench/rdioh_top_checker.sv
// Port-level assertions for the dedicated I/O handler
`timescale 1ns/1ps
`default_nettype none
module rdioh_top_checker (
  input wire logic       ref_clk,
  input wire logic       sys_rst,
  input wire logic       override_value_request,
  input wire logic       error_number_request,
  input wire logic       external_jog_enable,
  input wire logic       externalJogDisable,
  input wire logic [1:0] jog_mode_select,
  input wire logic [2:0] handFaultIn,
  input wire logic [2:0] pneumaticFaultIn,
  input wire logic [2:0] partsDue,
  input wire logic       overrideOutFlag,
  input wire logic       errorOutFlag,
  input wire logic       jogValid,
  input wire logic [1:0] jogModeActive,
  input wire logic [7:0] jogPlusActive,
  input wire logic [7:0] jogMinusActive,
  input wire logic [2:0] hand_fault,
  input wire logic [2:0] pneumatic_fault,
  input wire logic [2:0] parts_replacement_warning
);
  logic [2:0] rstHist_r;
  logic       clean;
  // Level mirrors are compared only once the sync pipe holds no reset values
  always_ff @(posedge ref_clk) begin
    rstHist_r <= {rstHist_r[1:0], sys_rst};
  end
  assign clean = (rstHist_r == 3'h0);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (sys_rst);
  hand_fault_a: assert property (clean |-> hand_fault == $past(handFaultIn, 3))
    else $error("hand fault output off");
  air_fault_a: assert property (clean |-> pneumatic_fault == $past(pneumaticFaultIn, 3))
    else $error("pneumatic fault output off");
  parts_warn_a: assert property (clean |-> parts_replacement_warning == $past(partsDue, 3))
    else $error("parts warning off");
  jog_mode_a: assert property (clean |-> jogModeActive == $past(jog_mode_select, 3))
    else $error("jog mode report off");
  jog_refused_a: assert property (!$past(jogValid)
    |-> (jogPlusActive == 8'h00) && (jogMinusActive == 8'h00))
    else $error("jog feed while jog invalid");
  ovr_flag_a: assert property ($rose(override_value_request) && !error_number_request
    |-> ##[3:5] (overrideOutFlag && !errorOutFlag))
    else $error("override report missing");
  err_flag_a: assert property ($rose(error_number_request) |-> ##[3:5] (errorOutFlag && !overrideOutFlag))
    else $error("error number report missing");
  jog_valid_a: assert property ($rose(external_jog_enable) && !externalJogDisable |-> ##[2:4] jogValid)
    else $error("jog valid not raised");
endmodule
bind rdioh_top rdioh_top_checker rdioh_top_checker_inst (
  .ref_clk(ref_clk), .sys_rst(sys_rst), .override_value_request(override_value_request),
  .error_number_request(error_number_request), .external_jog_enable(external_jog_enable),
  .externalJogDisable(externalJogDisable), .jog_mode_select(jog_mode_select), .handFaultIn(handFaultIn),
  .pneumaticFaultIn(pneumaticFaultIn), .partsDue(partsDue), .overrideOutFlag(overrideOutFlag),
  .errorOutFlag(errorOutFlag), .jogValid(jogValid), .jogModeActive(jogModeActive),
  .jogPlusActive(jogPlusActive), .jogMinusActive(jogMinusActive), .hand_fault(hand_fault),
  .pneumatic_fault(pneumatic_fault),
  .parts_replacement_warning(parts_replacement_warning)
);
`default_nettype wire

// file: bench/rdioh_plc_model.sv
// External sequencer model driving the request pins
`timescale 1ns/1ps
`default_nettype none
module rdioh_plc_model (
  input  wire logic       ref_clk,
  output var logic  [3:0] reqPins,
  output var logic  [1:0] modeSel,
  output var logic  [7:0] plusReq,
  output var logic  [7:0] minusReq
);
  initial begin
    reqPins = 4'h0;
    modeSel = 2'h0;
    plusReq = 8'h00;
    minusReq = 8'h00;
  end
  // edge request pulse
  // Held two scans, then low so the next rise re-arms
  task automatic pulse(input logic [3:0] mask);
    @(negedge ref_clk);
    reqPins = reqPins | mask;
    repeat (2) @(negedge ref_clk);
    reqPins = reqPins & ~mask;
  endtask
  task automatic level(input logic [1:0] m, input logic [7:0] p, input logic [7:0] n);
    @(negedge ref_clk);
    modeSel = m;
    plusReq = p;
    minusReq = n;
  endtask
endmodule
`default_nettype wire

// file: bench/test_robot_dedicated_io_handler.sv
// Self-checking bench for the dedicated I/O handler
`timescale 1ns/1ps
`default_nettype none
module test_robot_dedicated_io_handler;
  logic        clk, rst, ovrFlag, errFlag, jogValid;
  logic [3:0]  req;
  logic [1:0]  mode, modeAct;
  logic [7:0]  plus, minus, plusAct, minusAct, inZone, zFlags;
  logic [2:0]  handF, airF, partsF, handO, airO, partsO, zStart, zEnd;
  logic [23:0] genOut, handIn, genMir, inMir;
  logic [15:0] ovrVal, errNum, numIn, numOut, numInL;
  int          nFail, numChecks;
  rdioh_plc_model rdioh_plc_model_inst (.ref_clk(clk), .reqPins(req), .modeSel(mode), .plusReq(plus),
    .minusReq(minus));
  rdioh_top rdioh_top_inst (.ref_clk(clk), .sys_rst(rst), .override_value_request(req[0]),
    .error_number_request(req[1]), .external_jog_enable(req[2]), .externalJogDisable(req[3]),
    .jog_mode_select(mode), .jogPlusReq(plus), .jogMinusReq(minus), .handFaultIn(handF),
    .pneumaticFaultIn(airF), .partsDue(partsF), .genOutBits(genOut), .handInBits(handIn), .inZone(inZone),
    .zoneStartIdx(zStart), .zoneEndIdx(zEnd), .overrideValue(ovrVal), .errorNumber(errNum),
    .numericIn(numIn), .numericOut(numOut), .numericInLatched(numInL), .overrideOutFlag(ovrFlag),
    .errorOutFlag(errFlag), .jogValid(jogValid), .jogModeActive(modeAct), .jogPlusActive(plusAct),
    .jogMinusActive(minusAct), .hand_output_mirror(genMir), .hand_input_mirror(inMir),
    .hand_fault(handO), .pneumatic_fault(airO), .parts_replacement_warning(partsO), .user_zone_flag(zFlags));
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  task automatic cyc(input int n);
    repeat (n) @(negedge clk);
  endtask
  task automatic chk(input logic [23:0] got, input logic [23:0] exp);
    numChecks++;
    if (got !== exp) begin
      nFail++;
      $display("ERROR %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic numReq(input logic [3:0] m, input logic [15:0] num, input logic [1:0] flags);
    rdioh_plc_model_inst.pulse(m);
    cyc(6);
    chk(numOut, num);
    chk({ovrFlag, errFlag}, flags);
  endtask
  task automatic endSim;
    $display("Checks %0d mismatches %0d", numChecks, nFail);
    if (nFail == 0 && numChecks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  // ========================================
  // Test sequence
  initial begin
    {rst, handF, airF, partsF, genOut, handIn, inZone, zStart, zEnd} = {1'b1, 71'h0};
    {ovrVal, errNum, numIn, nFail, numChecks} = '0;
    cyc(12);
    rst = 1'b0;
    for (int m = 0; m < 3; m++) begin
      genOut = 24'h0000a5 << (8 * m);
      handIn = 24'h00005c << (8 * m);
      {handF, airF, partsF} = {3{3'h1 << m}};
      cyc(5);
      chk(genMir, genOut);
      chk(inMir, handIn);
      chk({handO, airO, partsO}, {3{3'h1 << m}});
    end
    {handF, airF} = 6'h00;
    cyc(5);
    chk({handO, airO}, 6'h00);
    $display("Test mirrors done");
    ovrVal = 16'h1234;
    errNum = 16'h0e5a;
    numReq(4'h1, 16'h1234, 2'h2);
    ovrVal = 16'h4321;
    cyc(2);
    chk(numOut, 16'h4321);
    numReq(4'h3, 16'h0e5a, 2'h1);
    rdioh_plc_model_inst.pulse(4'h1);
    numReq(4'h2, 16'h0e5a, 2'h1);
    // Override after error must win: last request, not error priority
    rdioh_plc_model_inst.pulse(4'h2);
    numReq(4'h1, 16'h4321, 2'h2);
    $display("Test numeric requests done");
    rdioh_plc_model_inst.level(2'h0, 8'ha5, 8'h5a);
    cyc(5);
    chk({plusAct, minusAct}, 16'h0000);
    rdioh_plc_model_inst.pulse(4'h4);
    cyc(6);
    chk({jogValid, plusAct, minusAct}, 17'h1a55a);
    for (int j = 0; j < 4; j++) begin
      rdioh_plc_model_inst.level(j[1:0], 8'h00, 8'h5a);
      cyc(5);
      chk({modeAct, plusAct, minusAct}, {j[1:0], 16'h005a});
    end
    rdioh_plc_model_inst.pulse(4'h8);
    cyc(6);
    chk({jogValid, minusAct}, 9'h000);
    $display("Test jog done");
    {inZone, zStart, zEnd} = {8'hff, 3'h2, 3'h5};
    cyc(5);
    chk(zFlags, 8'h3c);
    {zStart, zEnd} = {3'h6, 3'h1};
    cyc(5);
    chk(zFlags, 8'h00);
    numIn = 16'hbeef;
    cyc(5);
    chk(numInL, 16'hbeef);
    $display("Test zones done");
    rst = 1'b1;
    cyc(2);
    chk({numOut, ovrFlag, errFlag}, 18'h00000);
    rst = 1'b0;
    cyc(2);
    chk(numInL, 16'h0000);
    cyc(3);
    chk(numInL, 16'hbeef);
    $display("Test reset done");
    endSim();
  end
  initial begin
    cyc(2000);
    nFail++;
    endSim();
  end
endmodule
`default_nettype wire
